// *** hw/ppictl_pkg.sv ***
/*
 * ppictl_pkg: register map, field layout and reset values of the port
 * pull-up and input level control block.
 * Assumes: one 32-bit APB slave, each register one aligned word.
 */
package ppictl_pkg;
    localparam int PPICTL_NPINS = 6;
    localparam int PPICTL_AW = 8;
    // register byte offsets
    localparam logic [7:0] PPICTL_OFS_LEVELS = 8'h00;
    localparam logic [7:0] PPICTL_OFS_DIR = 8'h04;
    localparam logic [7:0] PPICTL_OFS_LATCH = 8'h08;
    localparam logic [7:0] PPICTL_OFS_ANSEL = 8'h0C;
    localparam logic [7:0] PPICTL_OFS_PULLUP = 8'h10;
    localparam logic [7:0] PPICTL_OFS_THRESH = 8'h14;
    localparam logic [7:0] PPICTL_OFS_OPTION = 8'h18;
    // field positions
    localparam int PPICTL_GPU_BIT = 7;
    localparam logic [5:0] PPICTL_ANSEL_MASK = 6'h17;
    // reset values
    localparam logic [5:0] PPICTL_RST_PULLUP = 6'h3F;
    localparam logic [5:0] PPICTL_RST_THRESH = 6'h04;
    localparam logic [5:0] PPICTL_RST_DIR = 6'h3F;
    localparam logic [5:0] PPICTL_RST_LATCH = 6'h00;
    localparam logic [5:0] PPICTL_RST_ANSEL = 6'h17;
    localparam logic PPICTL_RST_GPU = 1'b1;
    // apb slave phases
    typedef enum logic [1:0] {
        PPICTL_ST_IDLE = 2'b01,
        PPICTL_ST_ACC = 2'b10
    } ppictl_apb_st_t;
endpackage : ppictl_pkg

// *** hw/ppictl_pad.sv ***
/*
 * ppictl_pad: per-pin pull-up gating and input buffer selection.
 * Assumes: pad provides both a schmitt and a ttl resolved level per pin.
 */
`timescale 1ns/1ps
module ppictl_pad #(
    parameter int NPINS = 6
) (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // configuration
    input wire logic [NPINS-1:0] pullup_en,
    input wire logic [NPINS-1:0] thresh_st,
    input wire logic [NPINS-1:0] dir_in,
    input wire logic global_pullup_disable_n,
    // pad side
    input wire logic [NPINS-1:0] pin_st,
    input wire logic [NPINS-1:0] pin_ttl,
    output logic [NPINS-1:0] pullup_on_r,
    output logic [NPINS-1:0] level_r
);
    // gate each pull-up by the global bit and by direction
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pullup_on_r <= '0;
        end else begin
            pullup_on_r <= pullup_en & dir_in & {NPINS{~global_pullup_disable_n}};
        end
    end

    // pick schmitt or ttl level per pin
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            level_r <= '0;
        end else begin
            level_r <= (thresh_st & pin_st) | (~thresh_st & pin_ttl);
        end
    end
endmodule : ppictl_pad

// *** hw/ppictl_top.sv ***
/*
 * ppictl_top: six-pin port control with APB register access, pull-up
 * gating and input threshold selection.
 * Assumes: APB master in the clk domain; pads resolve levels externally.
 */
// Functional notes
// - pull-up enable bits 5..0, one per pin
// - pull-ups only when global disable bit clear
// - output pins lose pull-up one edge after their drive enable turns on
// - bits 7..6 of both registers read zero
// - threshold bit one schmitt, zero ttl
`timescale 1ns/1ps
module ppictl_top #(
    parameter int NPINS = ppictl_pkg::PPICTL_NPINS
) (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ppictl_pkg::PPICTL_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // port pins
    input wire logic [NPINS-1:0] port_pins_st,
    input wire logic [NPINS-1:0] port_pins_ttl,
    output logic [NPINS-1:0] port_pins_o,
    output logic [NPINS-1:0] port_pins_oe,
    output logic [NPINS-1:0] port_pins_pullup,
    output logic [NPINS-1:0] port_pins_analog
);
    import ppictl_pkg::*;

    logic [5:0] port_pin_pullup_enable_r;
    logic [5:0] port_input_threshold_select_r;
    logic [5:0] port_direction_r;
    logic [5:0] port_output_latch_r;
    logic [5:0] port_analog_select_r;
    logic global_pullup_disable_n_r;
    logic [NPINS-1:0] level_w;
    logic [NPINS-1:0] pull_w;
    logic [31:0] prdata_nxt;
    logic map_hit;
    ppictl_apb_st_t st_r;

    // true when the address names a register
    function automatic logic ppictl_hit(input logic [PPICTL_AW-1:0] a);
        ppictl_hit = (a == PPICTL_OFS_LEVELS) || (a == PPICTL_OFS_DIR) || (a == PPICTL_OFS_LATCH) ||
                     (a == PPICTL_OFS_ANSEL) || (a == PPICTL_OFS_PULLUP) || (a == PPICTL_OFS_THRESH) ||
                     (a == PPICTL_OFS_OPTION);
    endfunction : ppictl_hit

    logic wr_go;
    assign map_hit = ppictl_hit(paddr);
    assign wr_go = psel && penable && pwrite && (st_r == PPICTL_ST_ACC);

    // apb phase tracking: one wait state, answer on second access cycle
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st_r <= PPICTL_ST_IDLE;
        end else begin
            case (st_r)
                PPICTL_ST_IDLE: st_r <= (psel && penable) ? PPICTL_ST_ACC : PPICTL_ST_IDLE;
                PPICTL_ST_ACC: st_r <= PPICTL_ST_IDLE;
                default: st_r <= PPICTL_ST_IDLE;
            endcase
        end
    end

    // pready and pslverr registered, one cycle pulse
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && penable && (st_r == PPICTL_ST_IDLE) && !pready;
            pslverr <= psel && penable && (st_r == PPICTL_ST_IDLE) && !pready && !map_hit;
        end
    end

    // register writes take effect at the completing edge
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            port_pin_pullup_enable_r <= PPICTL_RST_PULLUP;
            port_input_threshold_select_r <= PPICTL_RST_THRESH;
            port_direction_r <= PPICTL_RST_DIR;
            port_output_latch_r <= PPICTL_RST_LATCH;
            port_analog_select_r <= PPICTL_RST_ANSEL;
            global_pullup_disable_n_r <= PPICTL_RST_GPU;
        end else if (wr_go && pready) begin
            case (paddr)
                PPICTL_OFS_PULLUP: port_pin_pullup_enable_r <= pwdata[5:0];
                PPICTL_OFS_THRESH: port_input_threshold_select_r <= pwdata[5:0];
                PPICTL_OFS_DIR: port_direction_r <= pwdata[5:0];
                PPICTL_OFS_LATCH, PPICTL_OFS_LEVELS: port_output_latch_r <= pwdata[5:0];
                PPICTL_OFS_ANSEL: port_analog_select_r <= pwdata[5:0] & PPICTL_ANSEL_MASK;
                PPICTL_OFS_OPTION: global_pullup_disable_n_r <= pwdata[PPICTL_GPU_BIT];
                default: ;
            endcase
        end
    end

    // read mux, upper bits zero
    always_comb begin
        prdata_nxt = 32'h0000_0000;
        case (paddr)
            PPICTL_OFS_LEVELS: prdata_nxt[5:0] = level_w;
            PPICTL_OFS_DIR: prdata_nxt[5:0] = port_direction_r;
            PPICTL_OFS_LATCH: prdata_nxt[5:0] = port_output_latch_r;
            PPICTL_OFS_ANSEL: prdata_nxt[5:0] = port_analog_select_r;
            PPICTL_OFS_PULLUP: prdata_nxt[5:0] = port_pin_pullup_enable_r;
            PPICTL_OFS_THRESH: prdata_nxt[5:0] = port_input_threshold_select_r;
            PPICTL_OFS_OPTION: prdata_nxt[PPICTL_GPU_BIT] = global_pullup_disable_n_r;
            default: prdata_nxt = 32'h0000_0000;
        endcase
    end

    // read data registered with pready
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            prdata <= 32'h0000_0000;
        end else if (psel && penable && !pwrite && (st_r == PPICTL_ST_IDLE) && !pready) begin
            prdata <= prdata_nxt;
        end
    end

    // pin drive from latch and direction
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            port_pins_o <= '0;
            port_pins_oe <= '0;
            port_pins_analog <= '0;
            port_pins_pullup <= '0;
        end else begin
            port_pins_o <= port_output_latch_r;
            port_pins_oe <= ~port_direction_r;
            port_pins_analog <= port_analog_select_r;
            port_pins_pullup <= pull_w;
        end
    end

    ppictl_pad #(
        .NPINS(NPINS)
    ) u_pad (
        .clk(clk),
        .sys_rst(sys_rst),
        .pullup_en(port_pin_pullup_enable_r),
        .thresh_st(port_input_threshold_select_r),
        .dir_in(port_direction_r),
        .global_pullup_disable_n(global_pullup_disable_n_r),
        .pin_st(port_pins_st),
        .pin_ttl(port_pins_ttl),
        .pullup_on_r(pull_w),
        .level_r(level_w)
    );

    // access phase seen by an idle slave: the edge that launches pready
    sequence s_take;
        psel && penable && !pready && st_r == PPICTL_ST_IDLE;
    endsequence

    // completing edge of a transfer: pready sampled high in the access phase
    sequence s_done;
        psel && penable && pready && st_r == PPICTL_ST_ACC;
    endsequence

    // read taken at this edge
    sequence s_take_rd;
        s_take ##0 !pwrite;
    endsequence

    // write landing at this edge
    sequence s_done_wr;
        s_done ##0 pwrite;
    endsequence

    // pull-up off two edges after global disable is seen set
    a_pullup_global: assert property (@(posedge clk) disable iff (sys_rst)
        global_pullup_disable_n_r |-> ##2 (port_pins_pullup == '0))
        else $error("pull-up active while globally disabled");

    // a pin set as output two edges earlier shows no pull-up; sampled reset keeps the release edge out
    a_pullup_output: assert property (@(posedge clk) disable iff (sys_rst)
        !sys_rst |-> ##2 ((port_pins_pullup & ~$past(port_direction_r, 2)) == '0))
        else $error("pull-up active on output pin");

    // pull-up follows enable when input and global enabled
    a_pullup_follow: assert property (@(posedge clk) disable iff (sys_rst)
        !sys_rst |-> ##2 (port_pins_pullup == ($past(port_pin_pullup_enable_r, 2) & $past(port_direction_r, 2)
            & {NPINS{~$past(global_pullup_disable_n_r, 2)}})))
        else $error("pull-up does not follow enables");

    sequence s_rd_thresh;
        psel && penable && !pwrite && !pready && st_r == PPICTL_ST_IDLE
            && (paddr == PPICTL_OFS_THRESH || paddr == PPICTL_OFS_PULLUP);
    endsequence

    // unimplemented top bits read zero
    a_upper_zero: assert property (@(posedge clk) disable iff (sys_rst)
        s_rd_thresh |=> (prdata[7:6] == 2'b00 && pready))
        else $error("bits 7..6 not zero");

    // level picks schmitt or ttl per threshold bit, one edge late
    a_level_sel: assert property (@(posedge clk) disable iff (sys_rst)
        !sys_rst |=> (level_w == (($past(port_input_threshold_select_r) & $past(port_pins_st))
            | (~$past(port_input_threshold_select_r) & $past(port_pins_ttl)))))
        else $error("input buffer selection wrong");

    // every access completes in exactly one wait state
    a_apb_answer: assert property (@(posedge clk) disable iff (sys_rst)
        s_take |=> pready)
        else $error("apb answer late");

    // pull-up register write lands at the completing edge
    a_pullup_write: assert property (@(posedge clk) disable iff (sys_rst)
        (psel && penable && pwrite && pready && paddr == PPICTL_OFS_PULLUP && st_r == PPICTL_ST_ACC)
        |=> port_pin_pullup_enable_r == $past(pwdata[5:0]))
        else $error("pull-up write lost");

    // threshold write lands
    a_thresh_write: assert property (@(posedge clk) disable iff (sys_rst)
        (psel && penable && pwrite && pready && paddr == PPICTL_OFS_THRESH && st_r == PPICTL_ST_ACC)
        |=> port_input_threshold_select_r == $past(pwdata[5:0]))
        else $error("threshold write lost");

    // pready stands one cycle; a request still held after it is answered again two cycles later
    a_pready_pulse: assert property (@(posedge clk) disable iff (sys_rst)
        pready |=> !pready)
        else $error("pready held beyond one cycle");

    // error flag comes exactly when the address names no register
    a_slverr_decode: assert property (@(posedge clk) disable iff (sys_rst)
        s_take |=> (pslverr == !$past(map_hit)))
        else $error("error response does not match address decode");

    // no error flag outside a completing cycle
    a_slverr_alone: assert property (@(posedge clk) disable iff (sys_rst)
        pslverr |-> pready)
        else $error("error flag without pready");

    // a write to an unmapped address changes no register
    a_unmapped_quiet: assert property (@(posedge clk) disable iff (sys_rst)
        s_done_wr ##0 !map_hit |=> ($stable(port_pin_pullup_enable_r) && $stable(port_input_threshold_select_r)
            && $stable(port_direction_r) && $stable(port_output_latch_r) && $stable(port_analog_select_r)
            && $stable(global_pullup_disable_n_r)))
        else $error("unmapped write changed a register");

    // direction write lands; a cleared bit makes the pin an output
    a_dir_write: assert property (@(posedge clk) disable iff (sys_rst)
        s_done_wr ##0 (paddr == PPICTL_OFS_DIR) |=> port_direction_r == $past(pwdata[5:0]))
        else $error("direction write lost");

    // latch write lands, through its own offset or the pin level offset
    a_latch_write: assert property (@(posedge clk) disable iff (sys_rst)
        s_done_wr ##0 (paddr == PPICTL_OFS_LATCH || paddr == PPICTL_OFS_LEVELS)
        |=> port_output_latch_r == $past(pwdata[5:0]))
        else $error("output latch write lost");

    // analog select keeps only the pins that have an analog input
    a_ansel_write: assert property (@(posedge clk) disable iff (sys_rst)
        s_done_wr ##0 (paddr == PPICTL_OFS_ANSEL)
        |=> port_analog_select_r == ($past(pwdata[5:0]) & PPICTL_ANSEL_MASK))
        else $error("analog select write wrong");

    // global pull-up disable bit follows its write
    a_option_write: assert property (@(posedge clk) disable iff (sys_rst)
        s_done_wr ##0 (paddr == PPICTL_OFS_OPTION)
        |=> global_pullup_disable_n_r == $past(pwdata[PPICTL_GPU_BIT]))
        else $error("global pull-up bit write lost");

    // pull-up enable reads back in the low six bits, upper bits zero
    a_pullup_read: assert property (@(posedge clk) disable iff (sys_rst)
        s_take_rd ##0 (paddr == PPICTL_OFS_PULLUP)
        |=> prdata == {26'h0, $past(port_pin_pullup_enable_r)})
        else $error("pull-up enable read wrong");

    // threshold select reads back in the low six bits, upper bits zero
    a_thresh_read: assert property (@(posedge clk) disable iff (sys_rst)
        s_take_rd ##0 (paddr == PPICTL_OFS_THRESH)
        |=> prdata == {26'h0, $past(port_input_threshold_select_r)})
        else $error("threshold select read wrong");

    // pin level read shows the selected buffer output
    a_level_read: assert property (@(posedge clk) disable iff (sys_rst)
        s_take_rd ##0 (paddr == PPICTL_OFS_LEVELS)
        |=> prdata == {26'h0, $past(level_w)})
        else $error("pin level read wrong");

    // global disable bit reads back in bit 7 alone
    a_option_read: assert property (@(posedge clk) disable iff (sys_rst)
        s_take_rd ##0 (paddr == PPICTL_OFS_OPTION)
        |=> prdata == {24'h0, $past(global_pullup_disable_n_r), 7'h00})
        else $error("option read wrong");

    // unmapped read returns zero
    a_unmapped_read: assert property (@(posedge clk) disable iff (sys_rst)
        s_take_rd ##0 !map_hit |=> prdata == 32'h0000_0000)
        else $error("unmapped read not zero");

    // pins drive from latch and direction one edge after the registers
    a_pin_drive: assert property (@(posedge clk) disable iff (sys_rst)
        !sys_rst |=> (port_pins_o == $past(port_output_latch_r) && port_pins_oe == ~$past(port_direction_r)))
        else $error("pin drive does not follow latch and direction");

    // analog pin selection follows its register one edge late
    a_analog_drive: assert property (@(posedge clk) disable iff (sys_rst)
        !sys_rst |=> port_pins_analog == $past(port_analog_select_r))
        else $error("analog selection does not follow register");

    // no answer without a selected transfer
    a_idle_quiet: assert property (@(posedge clk) disable iff (sys_rst)
        !psel |=> !pready)
        else $error("pready without a transfer");
endmodule : ppictl_top

// *** tb/ppictl_pin_model.sv ***
/*
 * ppictl_pin_model: behavioural model of the six port pins and their pad
 * buffers, giving a schmitt and a ttl level for each pin.
 * Assumes: the bench drives the external source per pin; a mid level sits
 * between the thresholds, so the ttl buffer reads 1 and the schmitt reads 0.
 */
`timescale 1ns/1ps
module ppictl_pin_model (
    // clock
    input wire logic clk,
    // device side
    input wire logic [5:0] port_pins_o,
    input wire logic [5:0] port_pins_oe,
    input wire logic [5:0] port_pins_pullup,
    // external sources
    input wire logic [5:0] ext_drv,
    input wire logic [5:0] ext_hi,
    input wire logic [5:0] ext_mid,
    // buffer outputs
    output logic [5:0] port_pins_st,
    output logic [5:0] port_pins_ttl
);
    logic float_r = 1'b0;
    // an undriven pin without pull-up wanders every cycle
    always @(posedge clk) begin
        float_r <= ~float_r;
    end
    // resolve each pin: device drive, external source, pull-up, floating
    always_comb begin
        for (int i = 0; i < 6; i++) begin
            if (port_pins_oe[i]) begin
                port_pins_st[i] = port_pins_o[i];
                port_pins_ttl[i] = port_pins_o[i];
            end else if (ext_drv[i]) begin
                port_pins_st[i] = ext_hi[i] & ~ext_mid[i];
                port_pins_ttl[i] = ext_hi[i] | ext_mid[i];
            end else begin
                port_pins_st[i] = port_pins_pullup[i] | float_r;
                port_pins_ttl[i] = port_pins_pullup[i] | float_r;
            end
        end
    end
endmodule : ppictl_pin_model

// *** tb/test_port_pullup_input_level_ctrl.sv ***
/*
 * test_port_pullup_input_level_ctrl: apb register tests of pull-up gating
 * and input threshold selection.
 * Assumes: ppictl_pkg compiled first; pin model on the port side.
 */
`timescale 1ns/1ps
module test_port_pullup_input_level_ctrl;
    import ppictl_pkg::*;
    logic clk = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, err;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [5:0] st, ttl, po, poe, ppu, pan;
    logic [5:0] ext_drv = 6'h00, ext_hi = 6'h00, ext_mid = 6'h00;
    int err_count = 0, checked = 0;
    logic [5:0] thr_tab [3] = '{6'h2A, 6'h00, 6'h3F};
    // design and pin model
    ppictl_top i_dut (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .port_pins_st(st), .port_pins_ttl(ttl), .port_pins_o(po), .port_pins_oe(poe),
        .port_pins_pullup(ppu), .port_pins_analog(pan));
    ppictl_pin_model i_pins (.clk(clk), .port_pins_o(po), .port_pins_oe(poe), .port_pins_pullup(ppu),
        .ext_drv(ext_drv), .ext_hi(ext_hi), .ext_mid(ext_mid), .port_pins_st(st), .port_pins_ttl(ttl));
    // clock
    always #5 clk = ~clk;
    task complete_run;
        if (err_count == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : complete_run
    task check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // one apb transfer, held until pready is sampled high; only the watchdog ends a wait
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // write, then let the pad stage and output flop settle
    task wr_settle(input logic [7:0] a, input logic [31:0] wd);
        apb(1'b1, a, wd);
        repeat (2) @(posedge clk);
        #1;
    endtask : wr_settle
    // watchdog
    initial begin
        #200us;
        err_count++;
        complete_run();
    end
    // main sequence
    initial begin
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        #1;
        check(ppu, 6'h00);
        apb(1'b0, PPICTL_OFS_PULLUP, 0); check(rd, 32'h3F);
        apb(1'b0, PPICTL_OFS_THRESH, 0); check(rd, 32'h04);
        apb(1'b0, PPICTL_OFS_OPTION, 0); check(rd, 32'h80);
        apb(1'b1, PPICTL_OFS_PULLUP, 32'hFFFF_FFFF);
        apb(1'b0, PPICTL_OFS_PULLUP, 0); check(rd, 32'h3F);
        apb(1'b1, PPICTL_OFS_THRESH, 32'hFFFF_FFC0);
        apb(1'b0, PPICTL_OFS_THRESH, 0); check(rd, 32'h00);
        apb(1'b1, PPICTL_OFS_PULLUP, 32'h15);
        apb(1'b0, PPICTL_OFS_PULLUP, 0); check(rd, 32'h15);
        check(ppu, 6'h00);
        wr_settle(PPICTL_OFS_OPTION, 32'h00); check(ppu, 6'h15);
        wr_settle(PPICTL_OFS_OPTION, 32'h80); check(ppu, 6'h00);
        wr_settle(PPICTL_OFS_OPTION, 32'h00);
        wr_settle(PPICTL_OFS_PULLUP, 32'h3F);
        wr_settle(PPICTL_OFS_DIR, 32'h33); check(ppu, 6'h33);
        check(poe, 6'h0C);
        wr_settle(PPICTL_OFS_DIR, 32'h3F); check(ppu, 6'h3F);
        // unmapped offset: error with pready, write ignored, read zero
        apb(1'b1, 8'h1C, 32'hFFFF_FFFF);
        check(err, 1'b1);
        apb(1'b0, 8'h1C, 0);
        check(err, 1'b1);
        check(rd, 32'h0);
        apb(1'b0, PPICTL_OFS_DIR, 0);
        check(err, 1'b0);
        check(rd, 32'h3F);
        // latch through both offsets, analog select masked
        wr_settle(PPICTL_OFS_LATCH, 32'h2A);
        check(po, 6'h2A);
        wr_settle(PPICTL_OFS_LEVELS, 32'h15);
        check(po, 6'h15);
        wr_settle(PPICTL_OFS_ANSEL, 32'h2F);
        check(pan, 6'h07);
        // mid level on low pins: ttl reads 3F, schmitt reads 30
        @(posedge clk);
        ext_drv <= 6'h3F;
        ext_hi <= 6'h30;
        ext_mid <= 6'h0F;
        foreach (thr_tab[k]) begin
            wr_settle(PPICTL_OFS_THRESH, {26'h0, thr_tab[k]});
            apb(1'b0, PPICTL_OFS_LEVELS, 0);
            check(rd, {26'h0, (6'h30 & thr_tab[k]) | (6'h3F & ~thr_tab[k])});
        end
        complete_run();
    end
endmodule : test_port_pullup_input_level_ctrl
